// >>> twm_map.svh
`ifndef TWM_MAP_SVH
`define TWM_MAP_SVH
// register offsets
`define TWM_OFS_CTRL 8'h00
`define TWM_OFS_TIMING 8'h08
`define TWM_OFS_CUR 8'h0C
`define TWM_OFS_NEXT 8'h10
`define TWM_OFS_RX 8'h14
`define TWM_OFS_TX 8'h18
`define TWM_OFS_STAT 8'h1C
`define TWM_OFS_IEN 8'h20
`define TWM_OFS_IDIS 8'h24
`define TWM_OFS_MASK 8'h28
`define TWM_OFS_SCLR 8'h2C
// command word fields
`define TWM_C_READ 0
`define TWM_C_WIDE 11
`define TWM_C_SAME 12
`define TWM_C_START 13
`define TWM_C_STOP 14
`define TWM_C_VALID 15
`define TWM_C_CNT_LO 16
`define TWM_C_CNT_HI 23
`define TWM_C_PEC 24
`define TWM_C_ACKL 25
`define TWM_CMD_MASK 32'h03FFFFFF
`define TWM_CMD_RESET 32'h00000000
// control word bits
`define TWM_CR_MEN 0
`define TWM_CR_MDIS 1
`define TWM_CR_SMEN 4
`define TWM_CR_SMDIS 5
`define TWM_CR_STOP 8
// status bits
`define TWM_S_RX 0
`define TWM_S_TX 1
`define TWM_S_SLOT 2
`define TWM_S_DONE 3
`define TWM_S_IDLE 4
`define TWM_S_QUIET 5
`define TWM_S_ADDRESS_NACK_FLAG 8
`define TWM_S_DATA_NACK_FLAG 9
`define TWM_S_ARB 10
`define TWM_S_ALERT 11
`define TWM_S_SMBUS_TIMEOUT_FLAG 12
`define TWM_S_PEC 13
`define TWM_S_STOP 14
`define TWM_STICKY_MASK 15'h7F08
// bus timing, wide address prefix and PEC polynomial
`define TWM_BIT_NS 10000
`define TWM_CLK_NS 20
`define TWM_QUARTER_CYC (`TWM_BIT_NS / (4 * `TWM_CLK_NS))
`define TWM_WIDE_PREFIX 5'h1E
`define TWM_CRC_POLY 8'h07
`endif

// >>> twm_pkg.sv
`default_nettype none
package twm_pkg;
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_START = 6'h02,
      ST_BYTE = 6'h04,
      ST_ACK = 6'h08,
      ST_NEXT = 6'h10,
      ST_STOP = 6'h20
   } twm_state_t;
   typedef enum logic [1:0] {
      END_OK = 2'h0,
      END_FAIL = 2'h1,
      END_USER = 2'h2
   } twm_end_t;
endpackage
`default_nettype wire

// >>> twm_master.sv
// Behaviour
// - last received byte is NACKed when ack-final is 0, ACKed when 1
// - PEC shift register updates on every address and data bit, not on ACK bits, check skipped when off
// - with PEC on, transmitter appends PEC byte, receiver checks it
// - byte count includes the PEC byte when PEC is used
// - STOP after the last byte only when send-stop is set
// - command valid bit clears when the command finishes
// - send-start gives START on a free bus, repeated START when held
// - wide addressing bit selects 10-bit address, not with SMBus; the code also selects 10-bit with SMBus on
// - upper address bits ignored in 7-bit mode
// - direction bit: 0 transmit, 1 receive
// - next command moves to current when current is free
// - receive register holds received byte, transmit register takes bytes
// - stop-accepted flag set after a software stop, sticky
// - arbitration lost when sampled data line differs from driven level
// - address NAK and data NAK flags
// - sticky PEC error, timeout and alert flags
// - live bus-quiet and idle flags
// - command-done on success or after a software stop
// - live slot-free, transmit-room and receive-waiting flags
// - enable shown in status, status resets to 0x00000002
// - enable-set and enable-clear registers steer the mask
// - status clear writes clear sticky flags
// - NAK or timeout: no done, valid kept, STOP sent
// - arbitration loss: lines released, valid kept, no done
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "twm_map.svh"
module twm_master
   import twm_pkg::*;
#(
   parameter int QUARTER = `TWM_QUARTER_CYC
)
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic alert_n_in,
   output logic irq
);
   localparam logic [11:0] QLAST = 12'(QUARTER - 1);

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction

   function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
      return {c[6:0], 1'b0} ^ ((c[7] ^ b) ? `TWM_CRC_POLY : 8'h00);
   endfunction

   function automatic logic [7:0] addr_for(input logic [1:0] step, input logic [31:0] c);
      if (!c[`TWM_C_WIDE])
         return c[7:0];
      else if (step == 2'h1)
         return c[8:1];
      else if (step == 2'h2)
         return {`TWM_WIDE_PREFIX, c[10:9], 1'b1};
      else
         return {`TWM_WIDE_PREFIX, c[10:9], c[`TWM_C_READ] & c[`TWM_C_SAME]};
   endfunction

   logic [1:0] scl_sync, sda_sync, alert_sync;
   logic scl_s, sda_s, alert_prev;
   logic [11:0] qcnt;
   logic tick;
   logic master_on, smbus_on, stop_req;
   logic [7:0] slave_stretch_limit;
   logic [31:0] cur, nxt;
   logic [7:0] tx_byte, rx_byte;
   logic tx_full, rx_full;
   logic [14:0] sticky, irq_mask, ev_set;
   logic [31:0] status;
   twm_state_t state;
   twm_end_t end_kind;
   logic [1:0] phase, addr_step;
   logic [2:0] bitn;
   logic [7:0] sh, crc, remaining, smbus_timeout_flag_cnt;
   logic addr_byte, held, halt, got_nack;
   logic rx_push, tx_pop, cmd_finish;
   logic rx_dir, tx_data, pec_send, stretched, last_byte;

   wire wr_ctrl = reg_wr & hit(reg_addr, `TWM_OFS_CTRL);
   wire wr_cur = reg_wr & hit(reg_addr, `TWM_OFS_CUR);
   wire wr_nxt = reg_wr & hit(reg_addr, `TWM_OFS_NEXT);
   wire wr_tx = reg_wr & hit(reg_addr, `TWM_OFS_TX);
   wire rd_rx = reg_rd & hit(reg_addr, `TWM_OFS_RX);
   wire [31:0] wcmd = reg_wdata & `TWM_CMD_MASK;

   // pins pass two flip-flops before use
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         alert_sync <= 2'h3;
         alert_prev <= 1'b1;
      end
      else
      begin
         scl_sync <= {scl_sync[0], scl_in};
         sda_sync <= {sda_sync[0], sda_in};
         alert_sync <= {alert_sync[0], alert_n_in};
         alert_prev <= alert_sync[1];
      end
   end
   assign scl_s = scl_sync[1];
   assign sda_s = sda_sync[1];

   // quarter-bit enable
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         qcnt <= 12'h000;
      else if (qcnt == QLAST)
         qcnt <= 12'h000;
      else
         qcnt <= qcnt + 12'h001;
   end
   assign tick = (qcnt == QLAST);

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         master_on <= 1'b0;
         smbus_on <= 1'b0;
         stop_req <= 1'b0;
         slave_stretch_limit <= 8'h00;
      end
      else
      begin
         if (wr_ctrl && reg_wdata[`TWM_CR_MDIS])
            master_on <= 1'b0;
         else if (wr_ctrl && reg_wdata[`TWM_CR_MEN])
            master_on <= 1'b1;
         if (wr_ctrl && reg_wdata[`TWM_CR_SMDIS])
            smbus_on <= 1'b0;
         else if (wr_ctrl && reg_wdata[`TWM_CR_SMEN])
            smbus_on <= 1'b1;
         if (wr_ctrl && reg_wdata[`TWM_CR_STOP])
            stop_req <= 1'b1;
         else if (state == ST_IDLE && !held)
            stop_req <= 1'b0;
         if (reg_wr && hit(reg_addr, `TWM_OFS_TIMING))
            slave_stretch_limit <= reg_wdata[7:0];
      end
   end

   // current and next command
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         cur <= `TWM_CMD_RESET;
         nxt <= `TWM_CMD_RESET;
      end
      else
      begin
         if (wr_cur)
            cur <= wcmd;
         else if (wr_nxt && !cur[`TWM_C_VALID])
            cur <= wcmd;
         else if (!cur[`TWM_C_VALID] && nxt[`TWM_C_VALID])
            cur <= nxt;
         else if (cmd_finish)
            cur[`TWM_C_VALID] <= 1'b0;
         if (wr_nxt && cur[`TWM_C_VALID])
            nxt <= wcmd;
         else if (!wr_cur && !cur[`TWM_C_VALID] && nxt[`TWM_C_VALID])
            nxt[`TWM_C_VALID] <= 1'b0;
      end
   end

   // holding registers
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         tx_byte <= 8'h00;
         tx_full <= 1'b0;
         rx_byte <= 8'h00;
         rx_full <= 1'b0;
      end
      else
      begin
         if (wr_tx)
         begin
            tx_byte <= reg_wdata[7:0];
            tx_full <= 1'b1;
         end
         else if (tx_pop)
            tx_full <= 1'b0;
         if (rx_push)
         begin
            rx_byte <= sh;
            rx_full <= 1'b1;
         end
         else if (rd_rx)
            rx_full <= 1'b0;
      end
   end

   assign rx_dir = !addr_byte && cur[`TWM_C_READ];
   assign tx_data = !addr_byte && !cur[`TWM_C_READ];
   assign last_byte = (remaining == 8'h01);
   assign pec_send = cur[`TWM_C_PEC] && last_byte;
   assign stretched = (phase == 2'h2) && !scl_s;

   // bus engine
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state <= ST_IDLE;
         end_kind <= END_OK;
         phase <= 2'h0;
         addr_step <= 2'h0;
         bitn <= 3'h0;
         sh <= 8'h00;
         crc <= 8'h00;
         remaining <= 8'h00;
         smbus_timeout_flag_cnt <= 8'h00;
         addr_byte <= 1'b0;
         held <= 1'b0;
         halt <= 1'b0;
         got_nack <= 1'b0;
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
         rx_push <= 1'b0;
         tx_pop <= 1'b0;
         cmd_finish <= 1'b0;
         ev_set <= 15'h0000;
      end
      else
      begin
         rx_push <= 1'b0;
         tx_pop <= 1'b0;
         cmd_finish <= 1'b0;
         ev_set <= 15'h0000;
         ev_set[`TWM_S_ALERT] <= smbus_on && alert_prev && !alert_sync[1];
         if (wr_cur)
            halt <= 1'b0;
         if (!master_on)
         begin
            state <= ST_IDLE;
            phase <= 2'h0;
            held <= 1'b0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
         end
         else if (tick && stretched)
         begin
            smbus_timeout_flag_cnt <= smbus_timeout_flag_cnt + 8'h01;
            if (smbus_on && slave_stretch_limit != 8'h00 && smbus_timeout_flag_cnt >= slave_stretch_limit
                && state != ST_STOP)
            begin
               ev_set[`TWM_S_SMBUS_TIMEOUT_FLAG] <= 1'b1;
               end_kind <= END_FAIL;
               state <= ST_STOP;
               phase <= 2'h0;
               scl_oe <= 1'b1;
            end
         end
         else if (tick)
         begin
            smbus_timeout_flag_cnt <= 8'h00;
            unique case (state)
               ST_IDLE:
               begin
                  bitn <= 3'h0;
                  if (held && stop_req)
                  begin
                     end_kind <= END_USER;
                     state <= ST_STOP;
                  end
                  else if (cur[`TWM_C_VALID] && !halt)
                  begin
                     remaining <= cur[`TWM_C_CNT_HI:`TWM_C_CNT_LO];
                     addr_step <= 2'h0;
                     addr_byte <= 1'b0;
                     end_kind <= END_OK;
                     if (cur[`TWM_C_START] || !held)
                        state <= ST_START;
                     else
                        state <= ST_NEXT;
                  end
               end
               ST_START:
               begin
                  phase <= phase + 2'h1;
                  if (phase == 2'h0)
                     sda_oe <= 1'b0;
                  else if (phase == 2'h1)
                     scl_oe <= 1'b0;
                  else if (phase == 2'h2)
                     sda_oe <= 1'b1;
                  else
                  begin
                     scl_oe <= 1'b1;
                     held <= 1'b1;
                     sh <= addr_for(addr_step, cur);
                     if (addr_step == 2'h0)
                        crc <= 8'h00;
                     addr_byte <= 1'b1;
                     state <= ST_BYTE;
                  end
               end
               ST_BYTE:
               begin
                  if (phase == 2'h0)
                  begin
                     if (bitn == 3'h0 && tx_data && pec_send)
                     begin
                        sh <= crc;
                        sda_oe <= !crc[7];
                        phase <= 2'h1;
                     end
                     else if (bitn == 3'h0 && tx_data)
                     begin
                        if (tx_full)
                        begin
                           sh <= tx_byte;
                           tx_pop <= 1'b1;
                           sda_oe <= !tx_byte[7];
                           phase <= 2'h1;
                        end
                     end
                     else
                     begin
                        sda_oe <= rx_dir ? 1'b0 : !sh[7];
                        phase <= 2'h1;
                     end
                  end
                  else if (phase == 2'h1)
                  begin
                     scl_oe <= 1'b0;
                     phase <= 2'h2;
                  end
                  else if (phase == 2'h2)
                  begin
                     if (!rx_dir && sh[7] && !sda_s)
                     begin
                        ev_set[`TWM_S_ARB] <= 1'b1;
                        scl_oe <= 1'b0;
                        sda_oe <= 1'b0;
                        held <= 1'b0;
                        halt <= 1'b1;
                        phase <= 2'h0;
                        state <= ST_IDLE;
                     end
                     else
                     begin
                        crc <= crc_step(crc, sda_s);
                        sh <= {sh[6:0], sda_s};
                        phase <= 2'h3;
                     end
                  end
                  else
                  begin
                     scl_oe <= 1'b1;
                     phase <= 2'h0;
                     bitn <= bitn + 3'h1;
                     if (bitn == 3'h7)
                        state <= ST_ACK;
                  end
               end
               ST_ACK:
               begin
                  if (phase == 2'h0)
                  begin
                     if (!rx_dir)
                     begin
                        sda_oe <= 1'b0;
                        phase <= 2'h1;
                     end
                     else if (!rx_full)
                     begin
                        rx_push <= 1'b1;
                        sda_oe <= !(last_byte && !cur[`TWM_C_ACKL]);
                        phase <= 2'h1;
                     end
                  end
                  else if (phase == 2'h1)
                  begin
                     scl_oe <= 1'b0;
                     phase <= 2'h2;
                  end
                  else if (phase == 2'h2)
                  begin
                     got_nack <= sda_s;
                     phase <= 2'h3;
                  end
                  else
                  begin
                     scl_oe <= 1'b1;
                     // data line is let go a tick later, once the clock is surely low
                     phase <= 2'h0;
                     if (!rx_dir && got_nack)
                     begin
                        ev_set[`TWM_S_ADDRESS_NACK_FLAG] <= addr_byte;
                        ev_set[`TWM_S_DATA_NACK_FLAG] <= !addr_byte;
                        end_kind <= END_FAIL;
                        state <= ST_STOP;
                     end
                     else if (rx_dir && last_byte && cur[`TWM_C_PEC] && crc != 8'h00)
                     begin
                        ev_set[`TWM_S_PEC] <= 1'b1;
                        end_kind <= END_FAIL;
                        state <= ST_STOP;
                     end
                     else
                     begin
                        if (!addr_byte)
                           remaining <= remaining - 8'h01;
                        state <= ST_NEXT;
                     end
                  end
               end
               ST_NEXT:
               begin
                  sda_oe <= 1'b0;
                  if (stop_req)
                  begin
                     end_kind <= END_USER;
                     state <= ST_STOP;
                  end
                  else if (addr_byte && cur[`TWM_C_WIDE] && addr_step == 2'h0
                           && !(cur[`TWM_C_READ] && cur[`TWM_C_SAME]))
                  begin
                     addr_step <= 2'h1;
                     sh <= addr_for(2'h1, cur);
                     state <= ST_BYTE;
                  end
                  else if (addr_byte && cur[`TWM_C_WIDE] && addr_step == 2'h1
                           && cur[`TWM_C_READ])
                  begin
                     addr_step <= 2'h2;
                     state <= ST_START;
                  end
                  else if (remaining != 8'h00)
                  begin
                     addr_byte <= 1'b0;
                     state <= ST_BYTE;
                  end
                  else if (cur[`TWM_C_STOP])
                     state <= ST_STOP;
                  else
                  begin
                     cmd_finish <= 1'b1;
                     ev_set[`TWM_S_DONE] <= 1'b1;
                     state <= ST_IDLE;
                  end
               end
               ST_STOP:
               begin
                  phase <= phase + 2'h1;
                  if (phase == 2'h0)
                     sda_oe <= 1'b1;
                  else if (phase == 2'h1)
                     scl_oe <= 1'b0;
                  else if (phase == 2'h3)
                  begin
                     sda_oe <= 1'b0;
                     held <= 1'b0;
                     state <= ST_IDLE;
                     halt <= (end_kind != END_OK);
                     cmd_finish <= (end_kind == END_OK);
                     ev_set[`TWM_S_DONE] <= (end_kind != END_FAIL);
                     ev_set[`TWM_S_STOP] <= (end_kind == END_USER);
                  end
               end
            endcase
         end
      end
   end

   // sticky flags, set wins over clear
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         sticky <= 15'h0000;
      else if (reg_wr && hit(reg_addr, `TWM_OFS_SCLR))
         sticky <= (sticky & ~(reg_wdata[14:0] & `TWM_STICKY_MASK)) | ev_set;
      else
         sticky <= sticky | ev_set;
   end

   assign status = {15'h0000, master_on, 1'b0, sticky[14:8], 2'b00,
                    master_on && state == ST_IDLE && !held && scl_s && sda_s,
                    master_on && state == ST_IDLE && !cur[`TWM_C_VALID] && !nxt[`TWM_C_VALID],
                    sticky[`TWM_S_DONE],
                    master_on && !(cur[`TWM_C_VALID] && nxt[`TWM_C_VALID]),
                    !tx_full, rx_full};

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         irq_mask <= 15'h0000;
         irq <= 1'b0;
      end
      else
      begin
         if (reg_wr && hit(reg_addr, `TWM_OFS_IEN))
            irq_mask <= irq_mask | reg_wdata[14:0];
         else if (reg_wr && hit(reg_addr, `TWM_OFS_IDIS))
            irq_mask <= irq_mask & ~reg_wdata[14:0];
         irq <= |(status[14:0] & irq_mask);
      end
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         reg_rdata <= 32'h00000000;
      else if (!reg_rd)
         reg_rdata <= 32'h00000000;
      else if (hit(reg_addr, `TWM_OFS_TIMING))
         reg_rdata <= {24'h000000, slave_stretch_limit};
      else if (hit(reg_addr, `TWM_OFS_CUR))
         reg_rdata <= cur;
      else if (hit(reg_addr, `TWM_OFS_NEXT))
         reg_rdata <= nxt;
      else if (hit(reg_addr, `TWM_OFS_RX))
         reg_rdata <= {24'h000000, rx_byte};
      else if (hit(reg_addr, `TWM_OFS_STAT))
         reg_rdata <= status;
      else if (hit(reg_addr, `TWM_OFS_MASK))
         reg_rdata <= {17'h00000, irq_mask};
      else
         reg_rdata <= 32'h00000000;
   end

   // open-drain lines only ever pull low
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         scl_out <= 1'b0;
         sda_out <= 1'b0;
      end
      else
      begin
         scl_out <= 1'b0;
         sda_out <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// >>> twm_master_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module twm_master_monitor (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic scl_in,
   input wire logic scl_out,
   input wire logic scl_oe,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic alert_n_in,
   input wire logic irq
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   sequence mask_cleared;
      reg_wr && reg_addr == 8'h24 && reg_wdata[14:0] == 15'h7FFF;
   endsequence
   sequence stop_edge;
      $fell(sda_oe) && !scl_oe;
   endsequence
   sequence start_edge;
      $rose(sda_oe) && !scl_oe;
   endsequence
   chk_open_drain: assert property (scl_out == 1'b0 && sda_out == 1'b0)
      else $error("bus line driven high");
   chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside its slot");
   chk_wo_reads: assert property (reg_rd && reg_addr inside {8'h18, 8'h20, 8'h24, 8'h30}
      |=> reg_rdata == 32'h0) else $error("write-only place read nonzero");
   chk_irq_masked: assert property (mask_cleared |=> ##1 !irq)
      else $error("irq with all mask bits cleared");
   chk_scl_low_hold: assert property ($rose(scl_oe) |=> scl_oe [*3])
      else $error("clock low phase too short");
   chk_scl_high_hold: assert property ($fell(scl_oe) |=> !scl_oe [*3])
      else $error("clock high phase too short");
   chk_stop_quiet: assert property (stop_edge |=> (!scl_oe && !sda_oe) [*3])
      else $error("bus not left free after stop");
   chk_start_hold: assert property (start_edge |=> sda_oe [*3])
      else $error("start condition too short");
endmodule
`default_nettype wire

// >>> twm_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
module twm_slave_model (
   input wire logic scl,
   input wire logic sda,
   input wire logic [6:0] own_addr,
   input wire logic [7:0] send_byte,
   output logic sda_pull,
   output logic [7:0] got_byte,
   output logic final_ack_level
);
   logic [7:0] sh = 8'h00;
   logic act = 1'b0;
   logic addr_ph = 1'b0;
   logic rd = 1'b0;
   logic hit = 1'b0;
   int cnt = 0;
   initial
   begin
      sda_pull = 1'b0;
   end
   // start or repeated start opens a frame, stop closes it
   always @(negedge sda)
      if (scl)
      begin
         act = 1'b1;
         addr_ph = 1'b1;
         cnt = 0;
      end
   always @(posedge sda)
      if (scl)
         act = 1'b0;
   always @(posedge scl)
      if (act)
      begin
         if (cnt < 8)
            sh = {sh[6:0], sda};
         else if (!addr_ph && rd)
            final_ack_level = sda;
         else if (!addr_ph)
            got_byte = sh;
         cnt = cnt + 1;
      end
   // lines change only while the clock is low
   always @(negedge scl)
   begin
      sda_pull = 1'b0;
      if (act && cnt == 9)
      begin
         cnt = 0;
         if (!addr_ph && rd && final_ack_level)
            hit = 1'b0;
         addr_ph = 1'b0;
      end
      if (act && hit && rd && !addr_ph && cnt < 8)
         sda_pull = !send_byte[7 - cnt];
      else if (act && cnt == 8 && addr_ph)
      begin
         hit = (sh[7:1] == own_addr);
         rd = sh[0];
         sda_pull = hit;
      end
      else if (act && cnt == 8 && hit && !rd)
         sda_pull = 1'b1;
   end
endmodule
`default_nettype wire

// >>> twm_master_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module twm_master_tb_top;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic alert_n_in = 1'b1;
   logic [31:0] reg_rdata, rv;
   logic scl_out, scl_oe, sda_out, sda_oe, irq, sda_pull, fin_ack;
   logic [7:0] got_byte;
   wire logic scl_w = !scl_oe;
   wire logic sda_w = !(sda_oe || sda_pull);
   int mismatches = 0;
   int checks_done = 0;
   twm_master #(.QUARTER(4)) dut_u (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .scl_in(scl_w), .scl_out, .scl_oe, .sda_in(sda_w), .sda_out, .sda_oe,
      .alert_n_in, .irq);
   twm_slave_model slave_u (.scl(scl_w), .sda(sda_w), .own_addr(7'h2A), .send_byte(8'h3C),
      .sda_pull, .got_byte, .final_ack_level(fin_ack));
   initial
   begin
      forever #10 clk = !clk;
   end
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         mismatches++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic wait_stat(input int b);
      int n;
      n = 0;
      rv = 32'h0;
      while (rv[b] !== 1'b1 && n < 3000)
      begin
         rd(8'h1C, rv);
         n++;
      end
      if (rv[b] !== 1'b1)
      begin
         mismatches++;
         $display("MISMATCH t=%0t status bit %0d never set", $time, b);
         close_out();
      end
   endtask
   task automatic regs_after_reset;
      logic [7:0] offs [6] = '{8'h1C, 8'h0C, 8'h10, 8'h28, 8'h18, 8'h30};
      foreach (offs[i])
      begin
         rd(offs[i], rv);
         chk(rv, i == 0 ? 32'h2 : 32'h0);
      end
   endtask
   task automatic mask_and_irq;
      wr(8'h00, 32'h1);
      rd(8'h1C, rv);
      chk(rv & 32'h10016, 32'h10016);
      wr(8'h20, 32'h6);
      wr(8'h20, 32'h0);
      rd(8'h28, rv);
      chk(rv, 32'h6);
      chk(irq, 1'b1);
      wr(8'h24, 32'h7FFF);
      rd(8'h28, rv);
      chk(rv, 32'h0);
      chk(irq, 1'b0);
   endtask
   task automatic write_one;
      wr(8'h18, 32'hA5);
      wr(8'h0C, 32'h0001E754);
      wait_stat(3);
      chk(got_byte, 8'hA5);
      rd(8'h1C, rv);
      chk(rv & 32'h3F38, 32'h38);
      rd(8'h0C, rv);
      chk(rv[15], 1'b0);
      wr(8'h2C, 32'h8);
      rd(8'h1C, rv);
      chk(rv[3], 1'b0);
   endtask
   task automatic addr_nak;
      wr(8'h0C, 32'h0001E022);
      wait_stat(8);
      chk(rv[3], 1'b0);
      rd(8'h0C, rv);
      chk(rv[15], 1'b1);
      wait_stat(5);
      wr(8'h2C, 32'h100);
      wr(8'h0C, 32'h0);
      rd(8'h1C, rv);
      chk(rv[8], 1'b0);
   endtask
   task automatic read_one;
      wr(8'h10, 32'h0001E055);
      rd(8'h10, rv);
      chk(rv[15], 1'b0);
      rd(8'h0C, rv);
      chk(rv, 32'h0001E055);
      wait_stat(3);
      chk(rv[0], 1'b1);
      chk(fin_ack, 1'b1);
      rd(8'h14, rv);
      chk(rv, 32'h3C);
   endtask
   task automatic user_stop;
      wr(8'h2C, 32'h8);
      wr(8'h18, 32'h5A);
      wr(8'h0C, 32'h0001A054);
      wait_stat(3);
      rd(8'h1C, rv);
      chk(rv[5], 1'b0);
      chk(got_byte, 8'h5A);
      wr(8'h00, 32'h100);
      wait_stat(14);
      chk(rv[3], 1'b1);
   endtask
   task automatic alert_flag;
      wr(8'h00, 32'h10);
      alert_n_in <= 1'b0;
      repeat (4) @(posedge clk);
      rd(8'h1C, rv);
      chk(rv[11], 1'b1);
      @(posedge clk);
      alert_n_in <= 1'b1;
      wr(8'h2C, 32'h800);
      rd(8'h1C, rv);
      chk(rv[11], 1'b0);
   endtask
   initial
   begin
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      regs_after_reset();
      mask_and_irq();
      write_one();
      addr_nak();
      read_one();
      user_stop();
      alert_flag();
      close_out();
   end
endmodule
bind twm_master twm_master_monitor mon_u (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata, .scl_in, .scl_out, .scl_oe, .sda_in, .sda_out, .sda_oe, .alert_n_in,
   .irq);
`default_nettype wire
